// file: common/fcs_defs.svh
// Purpose: constants for the flag conditioned signed sum slice
// Assumes: 32-bit instruction word, 9-bit register index
// Notes:   definitions only
`ifndef FCS_DEFS_SVH
`define FCS_DEFS_SVH

// ----------------------------------------------------------------------
// opcodes and condition
// ----------------------------------------------------------------------
`define FCS_OP_SUM_NEG_IF_ZERO     6'h26
`define FCS_OP_SUM_NEG_IF_NOT_ZERO 6'h27
`define FCS_COND_ALWAYS            4'hF

// ----------------------------------------------------------------------
// instruction field positions
// ----------------------------------------------------------------------
`define FCS_OP_MSB    31
`define FCS_OP_LSB    26
`define FCS_WZ_BIT    25
`define FCS_WC_BIT    24
`define FCS_WR_BIT    23
`define FCS_IMM_BIT   22
`define FCS_COND_MSB  21
`define FCS_COND_LSB  18
`define FCS_DST_MSB   17
`define FCS_DST_LSB   9
`define FCS_SRC_MSB   8
`define FCS_SRC_LSB   0

// ----------------------------------------------------------------------
// timing, map and reset values
// ----------------------------------------------------------------------
`define FCS_EXEC_CLOCKS  4
`define FCS_LAST_CNT     2'((`FCS_EXEC_CLOCKS) - 1)
`define FCS_FLAG_IDX     10'h200
`define FCS_RF_RESET     32'h0000_0000
`define FCS_FLAG_RESET   1'h0

`endif

// file: common/fcs_pkg.sv
// Purpose: types of the flag conditioned signed sum slice
// Assumes: fcs_defs.svh holds the numbers
// Notes:   state record is one packed struct
`include "fcs_defs.svh"

package fcs_pkg;

   // ----------------------------------------------------------------------
   // sequencer states
   // ----------------------------------------------------------------------
   typedef enum logic [0:0] {
      FCS_IDLE = 1'b0,
      FCS_RUN  = 1'b1
   } fcs_state_e;

   typedef logic [511:0][31:0] fcs_rf_t;

   // ----------------------------------------------------------------------
   // whole module state
   // ----------------------------------------------------------------------
   typedef struct packed {
      fcs_state_e  state;
      logic [1:0]  cnt;
      logic [31:0] instr;
      logic        busy;
      logic        done;
      logic        zflag;
      logic        cflag;
      logic [31:0] result;
      logic [31:0] rdata;
      fcs_rf_t     rf;
   } fcs_state_s;

endpackage : fcs_pkg

// file: rtl/fcs_sum.sv
// Purpose: executes the two zero-flag conditioned signed sum instructions
// Assumes: 40 MHz clk_in, arst_n_in asynchronous active low
// Notes:   register file of 512 longs, reached by software over a plain port
//
// Overview of operation
// - sum_neg_if_zero negates source when zero flag set, else adds as is.
// - sum_neg_if_not_zero adds source as is when zero flag set, else negates.
// - opcode 100111 with condition 1111 decodes sum_neg_if_not_zero.
// - opcode 100110 decodes sum_neg_if_zero; 9-bit destination and source fields follow.
// - immediate bit picks the 9-bit literal instead of the source register.
// - destination register gives first operand and takes the sum.
// - with zero write effect, zero flag shows whether the 32-bit sum is zero.
// - with carry write effect, carry flag shows signed 32-bit overflow.
// - sum is written back by default; each instruction takes 4 clocks.
// - no-result effect suppresses write-back to the destination.
// - flags change only when their write effect is given, or on a bus write to the flag index.
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defs.svh"

module fcs_sum
   import fcs_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        arst_n_in,
   input  wire logic [31:0] instr_in,
   input  wire logic        issue_in,
   input  wire logic [9:0]  addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [31:0] rdata_out,
   output logic             busy_out,
   output logic             done_out,
   output logic             zero_flag_out,
   output logic             carry_flag_out,
   output logic      [31:0] result_out
);

   // ----------------------------------------------------------------------
   // state record
   // ----------------------------------------------------------------------
   fcs_state_s  st;
   fcs_state_s  next_st;

   // ----------------------------------------------------------------------
   // decode of the held instruction
   // ----------------------------------------------------------------------
   logic [5:0]  opcode;
   logic        write_zero_flag_effect;
   logic        write_carry_flag_effect;
   logic        result_write_effect;
   logic        imm;
   logic [3:0]  cond;
   logic [8:0]  dst_idx;
   logic [8:0]  src_idx;
   logic        is_sum_neg_if_zero;
   logic        is_sum_neg_if_not_zero;
   logic        op_valid;
   logic        last_clock;
   logic        exec;

   // field split and opcode match
   assign opcode                  = st.instr[`FCS_OP_MSB:`FCS_OP_LSB];
   assign write_zero_flag_effect  = st.instr[`FCS_WZ_BIT];
   assign write_carry_flag_effect = st.instr[`FCS_WC_BIT];
   assign result_write_effect     = st.instr[`FCS_WR_BIT]; // clear means no_result_write_effect
   assign imm                     = st.instr[`FCS_IMM_BIT];
   assign cond                    = st.instr[`FCS_COND_MSB:`FCS_COND_LSB];
   assign dst_idx                 = st.instr[`FCS_DST_MSB:`FCS_DST_LSB];
   assign src_idx                 = st.instr[`FCS_SRC_MSB:`FCS_SRC_LSB];
   assign is_sum_neg_if_zero      = (opcode == `FCS_OP_SUM_NEG_IF_ZERO);
   assign is_sum_neg_if_not_zero  = (opcode == `FCS_OP_SUM_NEG_IF_NOT_ZERO);
   assign op_valid                = (is_sum_neg_if_zero || is_sum_neg_if_not_zero)
                                    && (cond == `FCS_COND_ALWAYS);
   assign last_clock              = (st.state == FCS_RUN) && (st.cnt == `FCS_LAST_CNT);
   assign exec                    = last_clock && op_valid;

   // ----------------------------------------------------------------------
   // operand fetch and signed sum
   // ----------------------------------------------------------------------
   logic [31:0] signed_dest_operand;
   logic [31:0] signed_src_operand;
   logic        negate;
   logic [32:0] sum_ext;
   logic        overflow;

   // operand selection, negation choice and overflow
   assign signed_dest_operand = st.rf[dst_idx];
   assign signed_src_operand  = imm ? {23'h00_0000, src_idx} : st.rf[src_idx];
   assign negate              = is_sum_neg_if_zero ? st.zflag : !st.zflag;
   assign sum_ext             = negate
                                ? {signed_dest_operand[31], signed_dest_operand}
                                  - {signed_src_operand[31], signed_src_operand}
                                : {signed_dest_operand[31], signed_dest_operand}
                                  + {signed_src_operand[31], signed_src_operand};
   assign overflow            = sum_ext[32] ^ sum_ext[31];

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   // bus access first, instruction effects after so write-back wins
   always_comb
   begin
      next_st       = st;
      next_st.done  = 1'b0;
      next_st.rdata = 32'h0000_0000;
      if (rd_in)
      begin
         if (addr_in == `FCS_FLAG_IDX)
         begin
            next_st.rdata = {30'h0000_0000, st.cflag, st.zflag};
         end
         else if (!addr_in[9])
         begin
            next_st.rdata = st.rf[addr_in[8:0]];
         end
      end
      if (wr_in)
      begin
         if (addr_in == `FCS_FLAG_IDX)
         begin
            next_st.zflag = wdata_in[0];
            next_st.cflag = wdata_in[1];
         end
         else if (!addr_in[9])
         begin
            next_st.rf[addr_in[8:0]] = wdata_in;
         end
      end
      case (st.state)
         FCS_IDLE:
         begin
            if (issue_in)
            begin
               next_st.instr = instr_in;
               next_st.cnt   = 2'h0;
               next_st.busy  = 1'b1;
               next_st.state = FCS_RUN;
            end
         end
         FCS_RUN:
         begin
            next_st.cnt = st.cnt + 2'h1;
            if (last_clock)
            begin
               next_st.busy  = 1'b0;
               next_st.done  = 1'b1;
               next_st.state = FCS_IDLE;
               if (exec)
               begin
                  next_st.result = sum_ext[31:0];
                  if (result_write_effect)
                  begin
                     next_st.rf[dst_idx] = sum_ext[31:0];
                  end
                  if (write_zero_flag_effect)
                  begin
                     next_st.zflag = (sum_ext[31:0] == 32'h0000_0000);
                  end
                  if (write_carry_flag_effect)
                  begin
                     next_st.cflag = overflow;
                  end
               end
            end
         end
         default:
         begin
            next_st.state = FCS_IDLE;
            next_st.busy  = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------
   // all state cleared to constants under reset
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         st.state  <= FCS_IDLE;
         st.cnt    <= 2'h0;
         st.instr  <= 32'h0000_0000;
         st.busy   <= 1'b0;
         st.done   <= 1'b0;
         st.zflag  <= `FCS_FLAG_RESET;
         st.cflag  <= `FCS_FLAG_RESET;
         st.result <= 32'h0000_0000;
         st.rdata  <= 32'h0000_0000;
         st.rf     <= {512{`FCS_RF_RESET}};
      end
      else
      begin
         st <= next_st;
      end
   end

   // outputs straight from the state record
   assign rdata_out      = st.rdata;
   assign busy_out       = st.busy;
   assign done_out       = st.done;
   assign zero_flag_out  = st.zflag;
   assign carry_flag_out = st.cflag;
   assign result_out     = st.result;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!arst_n_in);

   logic bus_flag_wr;
   logic bus_dst_wr;
   assign bus_flag_wr = wr_in && (addr_in == `FCS_FLAG_IDX);
   assign bus_dst_wr  = wr_in && (addr_in == {1'b0, dst_idx});

   sequence s_accept;
      issue_in && !busy_out;
   endsequence

   sequence s_slot;
      busy_out [*4] ##1 (done_out && !busy_out);
   endsequence

   exec_slot_a: assert property (s_accept |=> s_slot)
      else $error("instruction slot is not four clocks");

   bad_decode_a: assert property ((s_accept and !((instr_in[31:26] == `FCS_OP_SUM_NEG_IF_ZERO
         || instr_in[31:26] == `FCS_OP_SUM_NEG_IF_NOT_ZERO) && instr_in[21:18] == `FCS_COND_ALWAYS))
         |-> ##4 (last_clock && !exec))
      else $error("undecoded instruction was executed");

   zero_result_a: assert property (exec && write_zero_flag_effect
         |=> zero_flag_out == (result_out == 32'h0000_0000))
      else $error("zero flag does not match sum");

   carry_ovf_a: assert property (exec && write_carry_flag_effect
         |=> carry_flag_out == $past(overflow))
      else $error("carry flag does not match overflow");

   flag_hold_a: assert property (last_clock && !(exec && write_zero_flag_effect)
         && !(exec && write_carry_flag_effect) && !bus_flag_wr
         |=> $stable(zero_flag_out) && $stable(carry_flag_out))
      else $error("flag changed without its effect");

   no_result_a: assert property (exec && !result_write_effect && !bus_dst_wr
         |=> st.rf[$past(dst_idx)] == $past(signed_dest_operand))
      else $error("destination written despite no-result effect");

   write_back_a: assert property (exec && result_write_effect
         |=> st.rf[$past(dst_idx)] == result_out)
      else $error("sum not written to destination");

   neg_zero_a: assert property (exec && is_sum_neg_if_zero
         |=> result_out == ($past(st.zflag) ? $past(signed_dest_operand) - $past(signed_src_operand)
                                            : $past(signed_dest_operand) + $past(signed_src_operand)))
      else $error("sum_neg_if_zero used wrong sign");

   neg_not_zero_a: assert property (exec && is_sum_neg_if_not_zero
         |=> result_out == ($past(st.zflag) ? $past(signed_dest_operand) + $past(signed_src_operand)
                                            : $past(signed_dest_operand) - $past(signed_src_operand)))
      else $error("sum_neg_if_not_zero used wrong sign");

   literal_src_a: assert property (exec && imm
         |-> signed_src_operand == {23'h00_0000, st.instr[8:0]})
      else $error("literal source not zero extended");

endmodule : fcs_sum
`default_nettype wire

// file: tb/fcs_sum_bench.sv
// Purpose: self-checking bench for the flag conditioned signed sum slice
// Assumes: 40 MHz clock, active low asynchronous reset, fcs_defs.svh constants
// Notes:   instructions and register port are driven by tasks
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defs.svh"

module fcs_sum_bench;
   logic        clk_in;
   logic        arst_n_in;
   logic [31:0] instr_in;
   logic        issue_in;
   logic [9:0]  addr_in;
   logic [31:0] wdata_in;
   logic        wr_in;
   logic        rd_in;
   logic [31:0] rdata_out;
   logic        busy_out;
   logic        done_out;
   logic        zero_flag_out;
   logic        carry_flag_out;
   logic [31:0] result_out;
   int          miscompares;
   int          num_checks;

   fcs_sum u_fcs_sum (
      .clk_in         (clk_in),
      .arst_n_in      (arst_n_in),
      .instr_in       (instr_in),
      .issue_in       (issue_in),
      .addr_in        (addr_in),
      .wdata_in       (wdata_in),
      .wr_in          (wr_in),
      .rd_in          (rd_in),
      .rdata_out      (rdata_out),
      .busy_out       (busy_out),
      .done_out       (done_out),
      .zero_flag_out  (zero_flag_out),
      .carry_flag_out (carry_flag_out),
      .result_out     (result_out)
   );

   // ---------------------------------------------------------------
   // clock
   // ---------------------------------------------------------------
   // 25 ns period
   always #12.5 clk_in = ~clk_in;

   // ---------------------------------------------------------------
   // compare and access tasks
   // ---------------------------------------------------------------
   task automatic chk32(input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("MISMATCH at %0t: expected %h, got %h", $time, e, g);
      end
   endtask : chk32

   task automatic chk1(input logic e, input logic g);
      chk32({31'h0, e}, {31'h0, g});
   endtask : chk1

   task automatic wr_reg(input logic [9:0] a, input logic [31:0] d);
      @(posedge clk_in);
      wr_in    <= 1'b1;
      addr_in  <= a;
      wdata_in <= d;
      @(posedge clk_in);
      wr_in    <= 1'b0;
   endtask : wr_reg

   // read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [9:0] a, input logic [31:0] e);
      @(posedge clk_in);
      rd_in   <= 1'b1;
      addr_in <= a;
      @(posedge clk_in);
      rd_in   <= 1'b0;
      #1;
      chk32(e, rdata_out);
   endtask : rd_chk

   function automatic logic [31:0] mk(input logic [5:0] op, input logic [2:0] eff, input logic imm,
                                      input logic [3:0] cnd, input logic [8:0] d, input logic [8:0] s);
      return {op, eff, imm, cnd, d, s};
   endfunction : mk

   // issue one instruction and count edges until done
   task automatic run_instr(input logic [31:0] ins);
      int n;
      @(posedge clk_in);
      instr_in <= ins;
      issue_in <= 1'b1;
      @(posedge clk_in);
      issue_in <= 1'b0;
      #1;
      chk1(1'b1, busy_out);
      n = 0;
      while (done_out !== 1'b1 && n < 10)
      begin
         @(posedge clk_in);
         #1;
         n++;
      end
      chk32(32'h0000_0004, 32'(n));
   endtask : run_instr

   // one truth table row with both flag effects and write-back
   task automatic run_row(input logic [5:0] op, input logic z, input logic [31:0] d, input logic [31:0] s,
                          input logic [31:0] ed, input logic ez, input logic ec);
      wr_reg(10'h001, d);
      wr_reg(10'h002, s);
      wr_reg(`FCS_FLAG_IDX, {30'h0, ~ec, z});
      run_instr(mk(op, 3'b111, 1'b0, `FCS_COND_ALWAYS, 9'h001, 9'h002));
      chk32(ed, result_out);
      chk1(ez, zero_flag_out);
      chk1(ec, carry_flag_out);
      rd_chk(10'h001, ed);
      rd_chk(10'h002, s);
   endtask : run_row

   task automatic stop_test;
      $display("checks %0d, miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : stop_test

   // ---------------------------------------------------------------
   // watchdog
   // ---------------------------------------------------------------
   // the tests need a few hundred cycles; give up after ten thousand
   initial
   begin
      #250_000;
      miscompares++;
      stop_test();
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      clk_in = 1'b0;
      arst_n_in = 1'b0;
      instr_in = 32'h0000_0000;
      issue_in = 1'b0;
      addr_in = 10'h000;
      wdata_in = 32'h0000_0000;
      wr_in = 1'b0;
      rd_in = 1'b0;
      miscompares = 0;
      num_checks = 0;
      repeat (8) @(posedge clk_in);
      arst_n_in <= 1'b1;
      // reset state and unmapped space
      rd_chk(`FCS_FLAG_IDX, 32'h0000_0000);
      rd_chk(10'h001, 32'h0000_0000);
      wr_reg(10'h3FF, 32'h1234_5678);
      rd_chk(10'h3FF, 32'h0000_0000);
      // negate when zero flag set
      run_row(`FCS_OP_SUM_NEG_IF_ZERO, 1'b0, 32'h0000_0001, 32'h0000_0001, 32'h0000_0002, 1'b0, 1'b0);
      run_row(`FCS_OP_SUM_NEG_IF_ZERO, 1'b1, 32'h0000_0001, 32'h0000_0001, 32'h0000_0000, 1'b1, 1'b0);
      run_row(`FCS_OP_SUM_NEG_IF_ZERO, 1'b1, 32'h8000_0000, 32'h0000_0001, 32'h7FFF_FFFF, 1'b0, 1'b1);
      run_row(`FCS_OP_SUM_NEG_IF_ZERO, 1'b1, 32'h7FFF_FFFF, 32'hFFFF_FFFF, 32'h8000_0000, 1'b0, 1'b1);
      run_row(`FCS_OP_SUM_NEG_IF_ZERO, 1'b1, 32'h0000_0000, 32'h8000_0000, 32'h8000_0000, 1'b0, 1'b1);
      // negate when zero flag clear
      run_row(`FCS_OP_SUM_NEG_IF_NOT_ZERO, 1'b0, 32'h0000_0001, 32'h0000_0001, 32'h0000_0000, 1'b1, 1'b0);
      run_row(`FCS_OP_SUM_NEG_IF_NOT_ZERO, 1'b0, 32'h8000_0000, 32'h0000_0001, 32'h7FFF_FFFF, 1'b0, 1'b1);
      run_row(`FCS_OP_SUM_NEG_IF_NOT_ZERO, 1'b1, 32'h7FFF_FFFF, 32'h0000_0001, 32'h8000_0000, 1'b0, 1'b1);
      run_row(`FCS_OP_SUM_NEG_IF_NOT_ZERO, 1'b1, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFE, 1'b0, 1'b0);
      // literal source, register at the same index must not be used
      wr_reg(10'h1FF, 32'h0000_0007);
      wr_reg(10'h005, 32'h0000_0000);
      wr_reg(`FCS_FLAG_IDX, 32'h0000_0001);
      run_instr(mk(`FCS_OP_SUM_NEG_IF_ZERO, 3'b111, 1'b1, `FCS_COND_ALWAYS, 9'h005, 9'h1FF));
      rd_chk(10'h005, 32'hFFFF_FE01);
      chk1(1'b0, zero_flag_out);
      // no-result effect keeps the destination
      run_instr(mk(`FCS_OP_SUM_NEG_IF_NOT_ZERO, 3'b110, 1'b1, `FCS_COND_ALWAYS, 9'h005, 9'h001));
      chk32(32'hFFFF_FE00, result_out);
      rd_chk(10'h005, 32'hFFFF_FE01);
      // no flag effects: both flags keep their values
      wr_reg(10'h001, 32'h0000_0007);
      wr_reg(10'h002, 32'h0000_0005);
      wr_reg(`FCS_FLAG_IDX, 32'h0000_0003);
      run_instr(mk(`FCS_OP_SUM_NEG_IF_ZERO, 3'b001, 1'b0, `FCS_COND_ALWAYS, 9'h001, 9'h002));
      rd_chk(10'h001, 32'h0000_0002);
      rd_chk(`FCS_FLAG_IDX, 32'h0000_0003);
      // wrong condition, then wrong opcode: nothing changes
      run_instr(mk(`FCS_OP_SUM_NEG_IF_ZERO, 3'b111, 1'b0, 4'h0, 9'h001, 9'h002));
      run_instr(mk(6'h25, 3'b111, 1'b0, `FCS_COND_ALWAYS, 9'h001, 9'h002));
      rd_chk(10'h001, 32'h0000_0002);
      rd_chk(`FCS_FLAG_IDX, 32'h0000_0003);
      chk32(32'h0000_0002, result_out);
      stop_test();
   end
endmodule : fcs_sum_bench
`default_nettype wire
